// file: rtl/hpsc_defines.vh
// Timing and encoding constants for the hub pin-strap configuration loader.
// Assumes a 250 MHz reference clock; included by bare name.
`ifndef HPSC_DEFINES_VH
`define HPSC_DEFINES_VH

// ==========================================================================
// Clock and timing
// ==========================================================================
`define HPSC_CLK_MHZ          250
`define HPSC_RST_HOLD_NS      2700
`define HPSC_RST_HOLD_CYC     ((`HPSC_RST_HOLD_NS * `HPSC_CLK_MHZ + 999) / 1000)
`define HPSC_GANG_LATE_US     20
`define HPSC_GANG_SAMPLE_CYC  ((`HPSC_GANG_LATE_US * `HPSC_CLK_MHZ) / 2)
`define HPSC_DIR_MIN_MS       50
`define HPSC_DIR_MAX_MS       60
`define HPSC_DIR_CYC          ((`HPSC_DIR_MIN_MS + `HPSC_DIR_MAX_MS) * 125000)
`define HPSC_CNT_W            24

// ==========================================================================
// Encodings
// ==========================================================================
`define HPSC_CLK_SRC_RSVD     2'h0
`define HPSC_CLK_SRC_48       2'h1
`define HPSC_CLK_SRC_27       2'h2
`define HPSC_CLK_SRC_12       2'h3
`define HPSC_PORTS_DEFAULT    3'h4
`define HPSC_REMOVABLE_DFLT   4'h0
`define HPSC_POL_DEFAULT      1'h1

`endif

// file: rtl/hpsc_hub_pin_strap_config.v
// Pin-strap configuration loader of a four-port hub: reset sequencing,
// strap latching and the shared gang-mode / suspend-flag pin.
// Assumes all strap inputs are synchronous to ref_clk and stable at reset.
`include "hpsc_defines.vh"

// What this block does
// - Hold internal reset until 2.7 us after core supply good.
// - External reset input also forces power-on reset.
// - Sample gang/individual strap within 20 us after reset release.
// - Strap low selects individual switching, high selects ganged.
// - Turn shared strap pin to output 50 to 60 ms after reset.
// - Drive suspend flag on shared pin during global suspend.
// - Power enables active high when polarity strap 1, else low.
// - Port-count straps 11,10,01,00 give 1,2,3,4 ports.
// - High non_removable_port_strap strap marks that port non-removable.
// - Clock straps 01 48 MHz, 10 27 MHz, 11 12 MHz.
// - Reduced-pin variant ignores count, removable, clock, polarity straps.
// - Memory port count valid 1..4, default 4 otherwise.
// - Memory removability bits 4:1 map ports; 1 is non-removable.
module hpsc_hub_pin_strap_config (
    input  wire       ref_clk,
    input  wire       nrst,
    input  wire       ext_reset_n,
    input  wire       core_supply_good,
    input  wire       reduced_pin_pkg,
    input  wire       gang_pin_in,
    input  wire       power_enable_polarity_strap,
    input  wire       port_count_strap_high,
    input  wire       port_count_strap_low,
    input  wire [3:0] non_removable_port_strap,
    input  wire       clock_select_strap_a,
    input  wire       clock_select_strap_b,
    input  wire       mem_config_valid,
    input  wire [2:0] mem_port_count,
    input  wire [7:0] port_removability_byte,
    input  wire       global_suspend,
    input  wire [3:0] port_power_request,
    output reg        por_active,
    output reg        config_done,
    output reg        gang_mode,
    output reg        gang_pin_out,
    output reg        gang_pin_oe,
    output reg        power_enable_polarity,
    output reg  [3:0] port_power_enable,
    output reg  [2:0] active_port_count,
    output reg  [3:0] active_port_mask,
    output reg  [3:0] non_removable_ports,
    output reg  [1:0] clock_source,
    output reg        clock_source_reserved
);

// ==========================================================================
// Reset sequencing
// ==========================================================================
// Counts worked out in 32 bits, then cut to the counter width
localparam integer RST_CYC_I  = `HPSC_RST_HOLD_CYC;
localparam integer GANG_CYC_I = `HPSC_GANG_SAMPLE_CYC;
localparam integer DIR_CYC_I  = `HPSC_DIR_CYC;
localparam [`HPSC_CNT_W-1:0] RST_CYC  = RST_CYC_I[`HPSC_CNT_W-1:0];
localparam [`HPSC_CNT_W-1:0] GANG_CYC = GANG_CYC_I[`HPSC_CNT_W-1:0];
localparam [`HPSC_CNT_W-1:0] DIR_CYC  = DIR_CYC_I[`HPSC_CNT_W-1:0];

localparam [1:0] ST_RESET  = 2'h0;
localparam [1:0] ST_SAMPLE = 2'h1;
localparam [1:0] ST_WAIT   = 2'h2;
localparam [1:0] ST_OUTPUT = 2'h3;

// A short external pulse still gets the full internal hold; the board
// is expected to hold its reset longer, but nothing here relies on it
// Counter runs on through sample and wait; only leaving or re-entering reset clears it
reg  [1:0]            state;
reg  [1:0]            next_state;
reg  [`HPSC_CNT_W-1:0] cnt;
reg  [`HPSC_CNT_W-1:0] next_cnt;
wire                  por_cause;

// Either source restarts the whole sequence
assign por_cause = ~core_supply_good | ~ext_reset_n;

// Decode of port-count straps, used on the strap path only
function [2:0] strap_ports;
    input hi;
    input lo;
    begin
        case ({hi, lo})
            2'b11:   strap_ports = 3'h1;
            2'b10:   strap_ports = 3'h2;
            2'b01:   strap_ports = 3'h3;
            default: strap_ports = 3'h4;
        endcase
    end
endfunction

function [3:0] ports_to_mask;
    input [2:0] n;
    begin
        case (n)
            3'h1:    ports_to_mask = 4'h1;
            3'h2:    ports_to_mask = 4'h3;
            3'h3:    ports_to_mask = 4'h7;
            default: ports_to_mask = 4'hF;
        endcase
    end
endfunction

// Memory count outside 1..4 falls back to all ports
function [2:0] mem_ports;
    input [2:0] n;
    begin
        if (n >= 3'h1 && n <= 3'h4) begin
            mem_ports = n;
        end else begin
            mem_ports = `HPSC_PORTS_DEFAULT;
        end
    end
endfunction

// Code 00 names no source; flagged so the core can refuse it
function is_reserved_clock;
    input [1:0] code;
    begin
        is_reserved_clock = (code == `HPSC_CLK_SRC_RSVD);
    end
endfunction

always @* begin
    next_state = state;
    next_cnt   = cnt + 1'b1;
    case (state)
        ST_RESET: begin
            // Release only after the hold time of a good supply
            if (cnt >= RST_CYC - 1'b1) begin
                next_state = ST_SAMPLE;
                next_cnt   = {`HPSC_CNT_W{1'b0}};
            end
        end
        ST_SAMPLE: begin
            // Wait a little so strap nets settle, well inside the limit
            if (cnt >= GANG_CYC - 1'b1) begin
                next_state = ST_WAIT;
            end
        end
        ST_WAIT: begin
            // Switch point sits midway in the allowed window
            if (cnt >= DIR_CYC - 1'b1) begin
                next_state = ST_OUTPUT;
            end
        end
        ST_OUTPUT: begin
            // Count frozen; the pin stays an output until reset
            next_cnt = cnt;
        end
        default: begin
            next_state = ST_RESET;
            next_cnt   = {`HPSC_CNT_W{1'b0}};
        end
    endcase
    if (por_cause) begin
        next_state = ST_RESET;
        next_cnt   = {`HPSC_CNT_W{1'b0}};
    end
end

always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        state <= ST_RESET;
        cnt   <= {`HPSC_CNT_W{1'b0}};
    end else begin
        state <= next_state;
        cnt   <= next_cnt;
    end
end

// ==========================================================================
// Strap latching, once per reset
// ==========================================================================
wire leave_reset  = (state == ST_RESET) && (next_state == ST_SAMPLE);
wire leave_sample = (state == ST_SAMPLE) && (next_state == ST_WAIT);

wire [2:0] mem_ports_ok = mem_ports(mem_port_count);

// Per port: strap (full package only) or loaded byte marks it fixed
wire [3:0] next_nonrem_bit;
genvar pi;
generate
    for (pi = 0; pi < 4; pi = pi + 1) begin : g_fixed
        wire from_strap = ~reduced_pin_pkg & non_removable_port_strap[pi];
        wire from_mem   = mem_config_valid & port_removability_byte[pi + 1];
        assign next_nonrem_bit[pi] = from_strap | from_mem;
    end
endgenerate

reg [2:0] next_ports;
reg [3:0] next_nonrem;
reg [1:0] next_clk;
reg       next_pol;

always @* begin
    if (reduced_pin_pkg) begin
        next_pol    = `HPSC_POL_DEFAULT;
        next_clk    = `HPSC_CLK_SRC_12;
        next_ports  = mem_config_valid ? mem_ports_ok : `HPSC_PORTS_DEFAULT;
        next_nonrem = next_nonrem_bit;
    end else begin
        next_pol    = power_enable_polarity_strap;
        next_clk    = {clock_select_strap_a, clock_select_strap_b};
        // Valid memory contents take precedence over the count straps
        next_ports  = mem_config_valid ? mem_ports_ok
                    : strap_ports(port_count_strap_high,
                                  port_count_strap_low);
        next_nonrem = next_nonrem_bit;
    end
end

// Follows the next state, so it falls on the latching edge itself
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        por_active <= 1'b1;
    end else begin
        por_active <= (next_state == ST_RESET);
    end
end

// Strap values are taken once, on the edge that leaves reset
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        power_enable_polarity <= `HPSC_POL_DEFAULT;
        active_port_count     <= `HPSC_PORTS_DEFAULT;
        active_port_mask      <= 4'hF;
        non_removable_ports   <= `HPSC_REMOVABLE_DFLT;
        clock_source          <= `HPSC_CLK_SRC_12;
        clock_source_reserved <= 1'b0;
    end else if (leave_reset) begin
        power_enable_polarity <= next_pol;
        active_port_count     <= next_ports;
        active_port_mask      <= ports_to_mask(next_ports);
        non_removable_ports   <= next_nonrem;
        clock_source          <= next_clk;
        clock_source_reserved <= is_reserved_clock(next_clk);
    end
end

// Gang level is taken at the end of the sample window
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        gang_mode   <= 1'b0;
        config_done <= 1'b0;
    end else begin
        if (leave_sample) begin
            gang_mode   <= gang_pin_in;
            config_done <= 1'b1;
        end
        // A new reset cause withdraws the settled flag at once
        if (next_state == ST_RESET) begin
            config_done <= 1'b0;
        end
    end
end

// ==========================================================================
// Shared pin and power enables
// ==========================================================================
// Enables stay off while the sequence is in or entering reset
wire       pwr_block  = (next_state == ST_RESET) || (state == ST_RESET);
wire       pwr_invert = ~power_enable_polarity;
wire [3:0] next_pwr;
wire [3:0] next_pwr_level;

genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_power
        // Ganged mode follows port 1's request on every active port
        wire req = gang_mode ? port_power_request[0]
                             : port_power_request[gi];
        assign next_pwr[gi] = req & active_port_mask[gi] & ~pwr_block;
        assign next_pwr_level[gi] = next_pwr[gi] ^ pwr_invert;
    end
endgenerate

always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        gang_pin_oe  <= 1'b0;
        gang_pin_out <= 1'b0;
    end else begin
        gang_pin_oe  <= (next_state == ST_OUTPUT);
        // Level and direction move together, so no early drive
        gang_pin_out <= (next_state == ST_OUTPUT) & global_suspend;
    end
end

// Off at reset: polarity resets to active high
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        port_power_enable <= 4'h0;
    end else begin
        port_power_enable <= next_pwr_level;
    end
end

endmodule // hpsc_hub_pin_strap_config

// file: verif/hpsc_board.sv
// Board model of the shared strap pin: resistor level while released.
// Assumes pin_oe is high only while the loader drives the pin.
module hpsc_board (
    input  wire pull_up,
    input  wire pin_out,
    input  wire pin_oe,
    output wire pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up selects ganged, pull-down individual
    assign pin_in = pin_oe ? pin_out : pull_up;
endmodule // hpsc_board

// file: verif/hpsc_checker_properties.sv
// Checker of the strap loader: reset timing, latching and pin direction.
// Assumes the loader's top-level ports and a 250 MHz ref_clk.
module hpsc_checker (
    input wire       ref_clk,
    input wire       nrst,
    input wire       ext_reset_n,
    input wire       core_supply_good,
    input wire       por_active,
    input wire       config_done,
    input wire       gang_pin_oe,
    input wire [2:0] active_port_count,
    input wire [3:0] active_port_mask,
    input wire [3:0] non_removable_ports,
    input wire [1:0] clock_source
);
    reg [23:0] cnt;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ======================================================================
    // Cycles since the last reset cause went away, saturating
    // ======================================================================
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) cnt <= 24'h0;
        else if (!(ext_reset_n && core_supply_good)) cnt <= 24'h0;
        else if (cnt != 24'hFFFFFF) cnt <= cnt + 24'h1;
    end
    sequence s_ext; !ext_reset_n ##1 !ext_reset_n; endsequence
    sequence s_settled; config_done ##1 config_done; endsequence
    property p_supply; !core_supply_good ##1 !core_supply_good |=> por_active;
    endproperty
    property p_ext; s_ext |=> por_active; endproperty
    // Tolerance of 1.2 percent early and 1.6 percent late on the 675-cycle hold
    property p_hold; cnt > 24'h0 && cnt < 24'h29B |-> por_active; endproperty
    property p_release; cnt == 24'h2AE |-> !por_active; endproperty
    property p_gang; cnt == 24'h1630 |-> config_done; endproperty
    property p_dir; cnt < 24'hBEBC20 |-> !gang_pin_oe; endproperty
    property p_keep; s_settled |-> $stable(clock_source) &&
        $stable(active_port_count) && $stable(non_removable_ports); endproperty
    property p_mask; !por_active |->
        active_port_mask == (4'hF >> (3'h4 - active_port_count)); endproperty
    a_supply: assert property (p_supply) else $error("no reset on supply");
    a_ext: assert property (p_ext) else $error("no reset on ext");
    a_hold: assert property (p_hold) else $error("reset left early");
    a_release: assert property (p_release) else $error("reset late");
    a_gang: assert property (p_gang) else $error("gang sample late");
    a_dir: assert property (p_dir) else $error("pin driven early");
    a_keep: assert property (p_keep) else $error("latched value moved");
    a_mask: assert property (p_mask) else $error("mask mismatch");
endmodule // hpsc_checker
bind hpsc_hub_pin_strap_config hpsc_checker u_chk (.ref_clk(ref_clk),
    .nrst(nrst), .ext_reset_n(ext_reset_n), .core_supply_good(core_supply_good),
    .por_active(por_active), .config_done(config_done), .gang_pin_oe(gang_pin_oe),
    .active_port_count(active_port_count), .active_port_mask(active_port_mask),
    .non_removable_ports(non_removable_ports), .clock_source(clock_source));

// file: verif/tb_top.sv
// Self-checking bench of the strap loader: random straps over many resets.
// Assumes the board model for the shared pin and the bound checker.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        nrst, ext_n, sup_ok, red, pull, pol, ph, pl, ca, cb, mval, susp;
    logic        por, done, gm, gin, gout, goe, epol, crsv, e_pol;
    logic [3:0]  nrs, preq, ppe, mask, nrp, e_nr;
    logic [2:0]  mcnt, cnt, e_cnt;
    logic [1:0]  csrc, e_ck;
    logic [7:0]  rbyte;
    logic [31:0] lfsr = 32'h63156967;
    int          miscompares = 0;
    int          checks_done = 0;
    hpsc_board brd (.pull_up(pull), .pin_out(gout), .pin_oe(goe), .pin_in(gin));
    hpsc_hub_pin_strap_config dut (.ref_clk(ref_clk), .nrst(nrst),
        .ext_reset_n(ext_n), .core_supply_good(sup_ok), .reduced_pin_pkg(red),
        .gang_pin_in(gin), .power_enable_polarity_strap(pol),
        .port_count_strap_high(ph), .port_count_strap_low(pl),
        .non_removable_port_strap(nrs), .clock_select_strap_a(ca),
        .clock_select_strap_b(cb), .mem_config_valid(mval),
        .mem_port_count(mcnt), .port_removability_byte(rbyte),
        .global_suspend(susp), .port_power_request(preq), .por_active(por),
        .config_done(done), .gang_mode(gm), .gang_pin_out(gout),
        .gang_pin_oe(goe), .power_enable_polarity(epol),
        .port_power_enable(ppe), .active_port_count(cnt),
        .active_port_mask(mask), .non_removable_ports(nrp),
        .clock_source(csrc), .clock_source_reserved(crsv));
    always #2 ref_clk = ~ref_clk;
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [2:0] exp_count();
        if (mval) return (mcnt >= 3'h1 && mcnt <= 3'h4) ? mcnt : 3'h4;
        return red ? 3'h4 : 3'h4 - {1'b0, ph, pl};
    endfunction
    function automatic logic [3:0] exp_power(input logic [2:0] n,
                                             input logic p);
        logic [3:0] m, r;
        m = 4'hF >> (3'h4 - n);
        r = (pull ? {4{preq[0]}} : preq) & m;
        return p ? r : ~r;
    endfunction
    task automatic final_report();
        if (miscompares == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] exp, act);
        checks_done++;
        if (exp !== act) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, act);
        end
    endtask
    // Bounded wait: 0 for reset release, 1 for gang sample done
    task automatic wait_for(input logic which);
        int n;
        n = 0;
        while ((which ? done !== 1'b1 : por !== 1'b0) && n < 8000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 8000) begin
            miscompares++;
            final_report();
        end
    endtask
    initial begin
        {nrst, red, pull, pol, ph, pl, ca, cb, mval, susp} = 10'h0;
        {ext_n, sup_ok, nrs, preq, mcnt, rbyte} = 21'h180000;
        repeat (4) @(negedge ref_clk);
        nrst = 1'b1;
        for (int i = 0; i < 12; i++) begin
            lfsr = next_rand(next_rand(lfsr));
            {ph, pl} = i[1:0];
            {ca, cb} = i[2:1];
            red = (i >= 10);
            {pull, pol, mval, mcnt, nrs, rbyte, preq, susp} = lfsr[22:0];
            if (i[0]) ext_n = 1'b0;
            else sup_ok = 1'b0;
            repeat (i[0] ? 700 : 3) @(negedge ref_clk);
            {ext_n, sup_ok} = 2'b11;
            wait_for(1'b0);
            @(negedge ref_clk);
            e_cnt = exp_count();
            e_nr = (red ? 4'h0 : nrs) | (mval ? rbyte[4:1] : 4'h0);
            e_ck = red ? 2'h3 : {ca, cb};
            e_pol = red | pol;
            // Second pass sees straps flipped after latching
            for (int k = 0; k < 2; k++) begin
                check("port_count", e_cnt, cnt);
                check("port_mask", (8'h1 << e_cnt) - 8'h1, mask);
                check("fixed_ports", e_nr, nrp);
                check("clock_source", e_ck, csrc);
                check("clock_reserved", e_ck == 2'h0, crsv);
                check("polarity", e_pol, epol);
                {ph, pl, ca, cb, nrs, pol, mval} = ~{ph, pl, ca, cb, nrs, pol, mval};
                wait_for(1'b1);
            end
            @(negedge ref_clk);
            check("gang_mode", pull, gm);
            check("power_enable", exp_power(e_cnt, e_pol), ppe);
            check("pin_out", 1'b0, gout);
            check("pin_dir", 1'b0, goe);
        end
        final_report();
    end
endmodule // tb_top
